//--- logic/cpu_clock_divider_control.sv
/*
 processor clock divider control register on a classic wishbone slave,
 with decoded slowdown and postscaler ratios.
 assumes inputs synchronous to clk_i, interrupt_i a pulse or level from
 the interrupt controller, current_oscillator_code_i from the oscillator
 control logic.
*/
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/100ps
`include "clock_divider_defs.svh"
`default_nettype none

module cpu_clock_divider_control (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [1:0] sel_i,
	input wire logic [15:0] dat_i,
	output logic [15:0] dat_o,
	output logic ack_o,
	output logic err_o,
	input wire logic interrupt_i,
	input wire logic [2:0] current_oscillator_code_i,
	output logic [3:0] slowdown_shift_o,
	output logic [3:0] postscaler_shift_o,
	output logic [31:0] system_clock_hz_o
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// code 7 jumps to divide by 256, so the shift is not the code itself
	function automatic logic [3:0] post_shift(input logic [2:0] code);
		logic [3:0] s;
		s = {1'h0, code};
		if (code == `CDC_POST_MAX_CODE) begin
			s = `CDC_POST_MAX_SHIFT;
		end
		return s;
	endfunction

	// the ratio field is only a request; enable decides whether it counts
	function automatic logic [3:0] slow_shift(
		input logic en,
		input logic [2:0] code
	);
		logic [3:0] s;
		s = 4'h0;
		if (en) begin
			s = {1'h0, code};
		end
		return s;
	endfunction

	// only the two rc sources have a rate known to this block
	function automatic logic [31:0] source_hz(input logic [2:0] osc);
		logic [31:0] f;
		f = 32'h0000_0000;
		if (osc == `CDC_OSC_FAST_RC) begin
			f = `CDC_FAST_RC_HZ;
		end else if (osc == `CDC_OSC_SLOW_RC) begin
			f = `CDC_SLOW_RC_HZ;
		end
		return f;
	endfunction

	// ****************************************************************
	// bus decode
	// ****************************************************************
	clock_divider_pkg::control_t ctl;
	logic recover_reg;
	logic [2:0] ratio_reg;
	logic slow_en_reg;
	logic [2:0] post_reg;
	logic ack_reg;
	logic err_reg;
	logic [15:0] rdata_reg;
	logic req;
	logic hit;
	logic wr_hit;
	logic rd_hit;
	logic irq_clear;

	// one wait state: ack follows the request by one edge, then drops
	assign req = cyc_i && stb_i && !ack_reg && !err_reg;
	assign hit = (adr_i == `CDC_OFS_CONTROL);
	// low byte lane carries no state, so sel_i[0] alone writes nothing
	assign wr_hit = req && hit && we_i && sel_i[1];
	assign rd_hit = req && hit && !we_i;
	assign ack_o = ack_reg;
	assign err_o = err_reg;
	assign dat_o = rdata_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'h0;
		end else begin
			ack_reg <= req && hit;
		end
	end

	// unmapped words answer with err so a stray access cannot hang
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_reg <= 1'h0;
		end else begin
			err_reg <= req && !hit;
		end
	end

	// read data stands only in the ack cycle, zero otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= 16'h0000;
		end else if (rd_hit) begin
			rdata_reg <= {ctl, 8'h00};
		end else begin
			rdata_reg <= 16'h0000;
		end
	end

	// ****************************************************************
	// control register
	// ****************************************************************
	assign ctl = {recover_reg, ratio_reg, slow_en_reg, post_reg};
	assign irq_clear = interrupt_i && recover_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			recover_reg <= `CDC_RST_RECOVER;
		end else if (wr_hit) begin
			recover_reg <= dat_i[`CDC_BIT_RECOVER];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ratio_reg <= `CDC_RST_SLOW;
		end else if (wr_hit) begin
			ratio_reg <= dat_i[`CDC_SLOW_HI:`CDC_SLOW_LO];
		end
	end

	// hardware clear wins over a same-cycle software set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_en_reg <= `CDC_RST_SLOW_EN;
		end else if (irq_clear) begin
			slow_en_reg <= 1'h0;
		end else if (wr_hit) begin
			slow_en_reg <= dat_i[`CDC_BIT_SLOW_EN];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			post_reg <= `CDC_RST_POST;
		end else if (wr_hit) begin
			post_reg <= dat_i[`CDC_POST_HI:`CDC_POST_LO];
		end
	end

	// ****************************************************************
	// ratio outputs
	// ****************************************************************
	clock_divider_pkg::ratios_t rat_next;
	logic [3:0] slow_shift_reg;
	logic [3:0] post_shift_reg;
	logic [31:0] hz_reg;
	logic [31:0] src_hz;

	// other sources give a system_clock_hz_o of zero; their rate is unknown here
	assign src_hz = source_hz(current_oscillator_code_i);

	always_comb begin
		rat_next.slowdown_shift =
			slow_shift(ctl.slowdown_enable, ctl.slowdown_ratio);
		rat_next.postscaler_shift = post_shift(ctl.fast_rc_postscaler);
		rat_next.system_clock_hz =
			src_hz >> rat_next.postscaler_shift;
	end

	// outputs lag the register by one edge; consumers must allow for it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_shift_reg <= 4'h0;
		end else begin
			slow_shift_reg <= rat_next.slowdown_shift;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			post_shift_reg <= 4'h0;
		end else begin
			post_shift_reg <= rat_next.postscaler_shift;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hz_reg <= 32'h0000_0000;
		end else begin
			hz_reg <= rat_next.system_clock_hz;
		end
	end

	assign slowdown_shift_o = slow_shift_reg;
	assign postscaler_shift_o = post_shift_reg;
	assign system_clock_hz_o = hz_reg;

endmodule

`default_nettype wire

//--- logic/clock_divider_defs.svh
/*
 offsets, field positions, reset values and timing figures for the
 processor clock divider control block.
 assumes nothing of its surroundings.
*/
`ifndef CLOCK_DIVIDER_DEFS_SVH
`define CLOCK_DIVIDER_DEFS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define CDC_ADDR_W 4
`define CDC_OFS_CONTROL 4'h0

// ****************************************************************
// field positions
// ****************************************************************
`define CDC_BIT_RECOVER 15
`define CDC_SLOW_HI 14
`define CDC_SLOW_LO 12
`define CDC_BIT_SLOW_EN 11
`define CDC_POST_HI 10
`define CDC_POST_LO 8

// ****************************************************************
// reset values
// ****************************************************************
`define CDC_RST_RECOVER 1'h0
`define CDC_RST_SLOW 3'h3
`define CDC_RST_SLOW_EN 1'h0
`define CDC_RST_POST 3'h1

// ****************************************************************
// oscillator codes, source rates and postscaler limit
// ****************************************************************
`define CDC_OSC_FAST_RC 3'h7
`define CDC_OSC_SLOW_RC 3'h6
`define CDC_FAST_RC_HZ 32'h007a_1200
`define CDC_SLOW_RC_HZ 32'h0007_a120
`define CDC_POST_MAX_CODE 3'h7
`define CDC_POST_MAX_SHIFT 4'h8

`endif

//--- logic/clock_divider_pkg.sv
/*
 types shared by the processor clock divider control block.
 assumes the defs header is compiled alongside.
*/
`default_nettype none

package clock_divider_pkg;

	typedef struct packed {
		logic recover_on_interrupt;
		logic [2:0] slowdown_ratio;
		logic slowdown_enable;
		logic [2:0] fast_rc_postscaler;
	} control_t;

	typedef struct packed {
		logic [3:0] slowdown_shift;
		logic [3:0] postscaler_shift;
		logic [31:0] system_clock_hz;
	} ratios_t;

endpackage

`default_nettype wire

//--- testbench/cdc_checker.sv
/* assertions on the clock divider control ports.
 assumes a bind onto cpu_clock_divider_control. */
`timescale 1ns/100ps
`default_nettype none
module cdc_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [1:0] sel_i,
	input wire logic [15:0] dat_i,
	input wire logic [15:0] dat_o,
	input wire logic ack_o,
	input wire logic err_o,
	input wire logic interrupt_i,
	input wire logic [2:0] current_oscillator_code_i,
	input wire logic [3:0] slowdown_shift_o,
	input wire logic [3:0] postscaler_shift_o,
	input wire logic [31:0] system_clock_hz_o
);
	// ****
	// last written word, one edge late
	// ****
	logic [15:0] wr_reg;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i) begin
		if (rst_i) wr_reg <= 16'h3100;
		else if (ack_o && we_i && sel_i[1]) wr_reg <= dat_i;
	end
	chk_irq_recover: assert property (
		interrupt_i && wr_reg[15] && !(ack_o && we_i)
		|-> ##2 slowdown_shift_o == 4'h0)
		else $error("recover clear missing");
	chk_ratio_on: assert property (
		$past(ack_o && we_i && sel_i[1]) && wr_reg[11]
		|-> slowdown_shift_o == {1'h0, wr_reg[14:12]})
		else $error("ratio wrong");
	chk_ratio_off: assert property (
		$past(ack_o && we_i && sel_i[1]) && !wr_reg[11]
		|-> slowdown_shift_o == 4'h0) else $error("ratio not 1:1");
	chk_fast_rate: assert property (
		!$past(rst_i) && $past(current_oscillator_code_i) == 3'h7
		|-> system_clock_hz_o == 32'h7a1200 >> postscaler_shift_o)
		else $error("fast rate wrong");
	chk_reset_post: assert property (
		$fell(rst_i) |=> postscaler_shift_o == 4'h1)
		else $error("postscaler reset wrong");
	chk_slow_rate: assert property (
		!$past(rst_i) && $past(current_oscillator_code_i) == 3'h6
		|-> system_clock_hz_o == 32'h7a120 >> postscaler_shift_o)
		else $error("slow rate wrong");
	chk_low_zero: assert property (
		ack_o && !we_i |-> dat_o[7:0] == 8'h00)
		else $error("low byte not zero");
	chk_ack_pulse: assert property (
		ack_o |=> !ack_o) else $error("ack longer than one cycle");
	cover property (err_o);
	cover property (ack_o && we_i);
	cover property (interrupt_i && wr_reg[15]);
endmodule
bind cpu_clock_divider_control cdc_checker chk_u (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.we_i(we_i),
	.sel_i(sel_i),
	.dat_i(dat_i),
	.dat_o(dat_o),
	.ack_o(ack_o),
	.err_o(err_o),
	.interrupt_i(interrupt_i),
	.current_oscillator_code_i(current_oscillator_code_i),
	.slowdown_shift_o(slowdown_shift_o),
	.postscaler_shift_o(postscaler_shift_o),
	.system_clock_hz_o(system_clock_hz_o)
);
`default_nettype wire

//--- testbench/testbench.sv
/* self-checking bench for the clock divider control block.
 assumes design and checker compiled first. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, interrupt_i, er, ack_o, err_o;
	logic [3:0] adr_i, slowdown_shift_o, postscaler_shift_o;
	logic [1:0] sel_i;
	logic [15:0] dat_i, dat_o, q, v;
	logic [2:0] current_oscillator_code_i;
	logic [31:0] system_clock_hz_o;
	int n_mismatch, n_checks;
	cpu_clock_divider_control dut_u (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.err_o(err_o),
		.interrupt_i(interrupt_i),
		.current_oscillator_code_i(current_oscillator_code_i),
		.slowdown_shift_o(slowdown_shift_o),
		.postscaler_shift_o(postscaler_shift_o),
		.system_clock_hz_o(system_clock_hz_o)
	);
	// ****
	// helpers
	// ****
	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(input string s, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one idle edge first keeps stb low between cycles
	task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
		do @(posedge clk_i); while (ack_o !== 1'h1 && err_o !== 1'h1);
		q = dat_o;
		er = err_o;
		{cyc_i, stb_i} <= 2'h0;
	endtask
	function automatic logic [31:0] hz(input logic [2:0] c, p);
		logic [3:0] s;
		s = (p == 3'h7) ? 4'h8 : {1'h0, p};
		return c == 3'h7 ? 32'h7a1200 >> s : c == 3'h6 ? 32'h7a120 >> s : 32'h0;
	endfunction
	initial begin
		{rst_i, cyc_i, stb_i, we_i, interrupt_i} = 5'h10;
		{adr_i, dat_i, sel_i} = 22'h3;
		current_oscillator_code_i = 3'h7;
		void'($urandom(18440));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		chk("post", postscaler_shift_o, 4'h1);
		chk("hz", system_clock_hz_o, 32'h3d0900);
		wb(1'h0, 4'h0, 16'h0);
		chk("rst", q, 16'h3100);
		for (int i = 0; i < 16; i++) begin
			v = i == 0 ? 16'hffff : i == 1 ? 16'h0000 : 16'($urandom);
			current_oscillator_code_i <= 3'h6 + 3'(i[0]);
			wb(1'h1, 4'h0, v);
			wb(1'h0, 4'h0, 16'h0);
			chk("rd", q, v & 16'hff00);
			chk("slow", slowdown_shift_o, v[11] ? v[14:12] : 3'h0);
			chk("hz", system_clock_hz_o, hz(3'h6 + 3'(i[0]), v[10:8]));
			chk("post", postscaler_shift_o, v[10:8] == 3'h7 ? 4'h8 : {1'h0, v[10:8]});
		end
		for (int k = 0; k < 2; k++) begin
			wb(1'h1, 4'h0, {k[0], 15'h1900});
			interrupt_i <= 1'h1;
			@(posedge clk_i);
			interrupt_i <= 1'h0;
			wb(1'h0, 4'h0, 16'h0);
			chk("irq", q, k ? 16'h9100 : 16'h1900);
			chk("irq shift", slowdown_shift_o, k ? 4'h0 : 4'h1);
		end
		sel_i <= 2'h1;
		wb(1'h1, 4'h0, 16'h0000);
		sel_i <= 2'h3;
		chk("sel err", er, 1'h0);
		wb(1'h1, 4'h5, 16'hffff);
		chk("err", er, 1'h1);
		wb(1'h0, 4'h0, 16'h0);
		chk("keep", q, 16'h9100);
		print_verdict();
	end
	initial begin
		#20000;
		n_mismatch++;
		print_verdict();
	end
endmodule
`default_nettype wire
